// ### rtl/mops_sync_ctrl.sv
// Multichip output phase sync control with its register bytes
`include "mops_map.svh"
`default_nettype none
module mops_sync_ctrl (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic wr_en_in,
    input wire mops_pkg::mops_addr_t addr_in,
    input wire mops_pkg::mops_byte_t wdata_in,
    input wire logic sync_pin_in,
    input wire logic ref_run_in,
    input wire logic freq_change_in,
    output mops_pkg::mops_byte_t rdata_out,
    output logic div_reset_out,
    output logic align_done_out,
    output logic sync_lvds_sel_out,
    output logic ref_type_sel_out,
    output logic divided_ref_clock_enable_out,
    output logic [5:0] ref_ratio_out
);
    import mops_pkg::*;

    mops_byte_t mode_q, mode_d, ratio_q, ratio_d, gates_q, gates_d;
    mops_byte_t refc_q, refc_d, syncc_q, syncc_d, rdata_q, rdata_d;
    mops_state_e st_q, st_d;
    logic pin_q, pin_d, run_q, run_d, dvr_q, dvr_d, done_q, done_d;
    logic [3:0] cnt_q, cnt_d;
    logic timed, ref_rst_en, realign_en, swreq;

    // Byte read decode
    function automatic mops_byte_t rd_mux(input mops_addr_t a,
        input mops_byte_t m, input mops_byte_t r, input mops_byte_t g,
        input mops_byte_t c, input mops_byte_t s);
        case (a)
            `MOPS_SYNC_MODE_OFS: rd_mux = m;
            `MOPS_REF_DIV_OFS: rd_mux = r;
            `MOPS_CLK_GATES_OFS: rd_mux = g;
            `MOPS_REF_CFG_OFS: rd_mux = c;
            `MOPS_SYNC_CFG_OFS: rd_mux = s;
            default: rd_mux = 8'h00;
        endcase
    endfunction

    assign timed = mode_q[`MOPS_TIMED_BIT];
    assign ref_rst_en = mode_q[`MOPS_REF_RST_BIT];
    assign realign_en = mode_q[`MOPS_REALIGN_BIT];
    assign swreq = mode_q[`MOPS_SWREQ_BIT];

    // Register writes and read data
    always_comb begin
        mode_d = mode_q;
        ratio_d = ratio_q;
        gates_d = gates_q;
        refc_d = refc_q;
        syncc_d = syncc_q;
        if (wr_en_in) begin
            case (addr_in)
                `MOPS_SYNC_MODE_OFS: mode_d = wdata_in;
                `MOPS_REF_DIV_OFS: ratio_d = {2'h0, wdata_in[5:0]};
                `MOPS_CLK_GATES_OFS: gates_d = wdata_in;
                `MOPS_REF_CFG_OFS: refc_d = wdata_in;
                `MOPS_SYNC_CFG_OFS: syncc_d = wdata_in;
                default: ;
            endcase
        end
        rdata_d = rd_mux(addr_in, mode_q, ratio_q, gates_q, refc_q,
            syncc_q);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_q <= `MOPS_REG_RST;
            ratio_q <= `MOPS_RATIO_RST;
            gates_q <= `MOPS_REG_RST;
            refc_q <= `MOPS_REG_RST;
            syncc_q <= `MOPS_REG_RST;
            rdata_q <= `MOPS_REG_RST;
        end else begin
            mode_q <= mode_d;
            ratio_q <= ratio_d;
            gates_q <= gates_d;
            refc_q <= refc_d;
            syncc_q <= syncc_d;
            rdata_q <= rdata_d;
        end
    end

    // Sequencer next state
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        done_d = done_q;
        dvr_d = 1'b0;
        pin_d = sync_pin_in;
        run_d = ref_run_in;
        case (st_q)
            MOPS_IDLE: begin
                if (timed && ref_rst_en && sync_pin_in && !pin_q) begin
                    st_d = MOPS_HOLD;
                    dvr_d = 1'b1;
                    done_d = 1'b0;
                end else if (!timed && ref_rst_en && swreq &&
                             ref_run_in && !run_q) begin
                    st_d = MOPS_RELEASE;
                    dvr_d = 1'b1;
                    cnt_d = `MOPS_RELEASE_CYC;
                    done_d = 1'b0;
                end else if (freq_change_in && !realign_en) begin
                    done_d = 1'b0;
                end
            end
            MOPS_HOLD: begin
                dvr_d = 1'b1;
                if (!sync_pin_in) begin
                    st_d = MOPS_RELEASE;
                    cnt_d = `MOPS_RELEASE_CYC;
                end
            end
            MOPS_RELEASE: begin
                dvr_d = 1'b1;
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    st_d = MOPS_ALIGNED;
                    dvr_d = 1'b0;
                    done_d = 1'b1;
                end
            end
            MOPS_ALIGNED: begin
                if (timed || !swreq) begin
                    st_d = MOPS_IDLE;
                end
            end
            default: st_d = MOPS_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= MOPS_IDLE;
            cnt_q <= 4'h0;
            pin_q <= 1'b0;
            // Running reference level, so no false restart after reset
            run_q <= 1'b1;
            dvr_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pin_q <= pin_d;
            run_q <= run_d;
            dvr_q <= dvr_d;
            done_q <= done_d;
        end
    end

    // Outputs from flops
    assign rdata_out = rdata_q;
    assign div_reset_out = dvr_q;
    assign align_done_out = done_q;
    assign sync_lvds_sel_out = syncc_q[`MOPS_SYNCSEL_BIT];
    assign ref_type_sel_out = refc_q[`MOPS_REFSEL_BIT];
    assign divided_ref_clock_enable_out = gates_q[`MOPS_DIV_REF_CLK_BIT];
    assign ref_ratio_out = ratio_q[`MOPS_RATIO_MSB:0];

    // Assertions beside the sequencer and register logic

    a_rise_holds: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_IDLE && timed && ref_rst_en && sync_pin_in && !pin_q
        |=> div_reset_out)
        else $error("rise did not reset");

    a_hold_stays: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_HOLD && sync_pin_in
        |=> st_q == MOPS_HOLD && div_reset_out)
        else $error("hold left early");

    a_fall_release: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_HOLD && !sync_pin_in
        |=> ##2 st_q == MOPS_ALIGNED)
        else $error("fall did not release");

    a_req_restart: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_IDLE && !timed && ref_rst_en && swreq && ref_run_in
        && !run_q |=> div_reset_out ##2 align_done_out)
        else $error("request not aligned");

    a_req_waits: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_ALIGNED && !timed && swreq
        |=> st_q == MOPS_ALIGNED && !div_reset_out)
        else $error("left aligned early");

    a_timed_sel: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_IDLE && !timed && sync_pin_in && !pin_q
        |=> st_q != MOPS_HOLD)
        else $error("pin used in request mode");

    a_rst_enable: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_IDLE && !ref_rst_en
        |=> !div_reset_out)
        else $error("reset without enable");

    a_lvds_sel: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        wr_en_in && addr_in == `MOPS_SYNC_CFG_OFS |=>
        sync_lvds_sel_out == $past(wdata_in[`MOPS_SYNCSEL_BIT]))
        else $error("sync select wrong");

    a_ratio_six: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        wr_en_in && addr_in == `MOPS_REF_DIV_OFS |=>
        ref_ratio_out == $past(wdata_in[`MOPS_RATIO_MSB:0]) && ratio_q[7:6] == 2'h0)
        else $error("ratio wrong");

    a_gate_bit: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        wr_en_in && addr_in == `MOPS_CLK_GATES_OFS |=>
        divided_ref_clock_enable_out ==
        $past(wdata_in[`MOPS_DIV_REF_CLK_BIT]))
        else $error("gate wrong");

    a_ref_type: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        wr_en_in && addr_in == `MOPS_REF_CFG_OFS |=>
        ref_type_sel_out == $past(wdata_in[`MOPS_REFSEL_BIT]))
        else $error("ref type wrong");

    a_keep_phase: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        align_done_out && realign_en && freq_change_in && st_q == MOPS_IDLE
        && !(timed || swreq) |=> align_done_out)
        else $error("phase lost");

    a_done_drop: assert property (
        @(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_IDLE && freq_change_in && !realign_en && !timed
        && !swreq |=> !align_done_out)
        else $error("status not dropped");

    // Timed sync reaches aligned
    c_timed: cover property (@(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_HOLD ##[1:20] st_q == MOPS_ALIGNED);
    // Request sync reaches aligned
    c_request: cover property (@(posedge clk_in) disable iff (!nrst_in)
        !timed && st_q == MOPS_RELEASE ##2 align_done_out);
    // Nonzero read data in the cycle after a write, taken from the register values before that write
    c_readback: cover property (@(posedge clk_in) disable iff (!nrst_in)
        wr_en_in ##1 rdata_out != 8'h00);
    // Status kept across a frequency change
    c_keep_phase: cover property (@(posedge clk_in) disable iff (!nrst_in)
        align_done_out && realign_en && freq_change_in ##1 align_done_out);
    // Pin pulse seen outside timed mode
    c_pin_refused: cover property (@(posedge clk_in) disable iff (!nrst_in)
        st_q == MOPS_IDLE && !timed && sync_pin_in && !pin_q);
endmodule // mops_sync_ctrl
`default_nettype wire

// ### rtl/mops_map.svh
// Register map constants of the output phase sync block
`ifndef MOPS_MAP_SVH
`define MOPS_MAP_SVH
`define MOPS_SYNC_MODE_OFS 12'h01E
`define MOPS_REF_DIV_OFS 12'h020
`define MOPS_CLK_GATES_OFS 12'h02D
`define MOPS_REF_CFG_OFS 12'h030
`define MOPS_SYNC_CFG_OFS 12'h053
`define MOPS_TIMED_BIT 5
`define MOPS_REF_RST_BIT 6
`define MOPS_REALIGN_BIT 7
`define MOPS_SWREQ_BIT 0
`define MOPS_DIV_REF_CLK_BIT 6
`define MOPS_REFSEL_BIT 5
`define MOPS_SYNCSEL_BIT 5
`define MOPS_RATIO_MSB 5
`define MOPS_REG_RST 8'h00
`define MOPS_RATIO_RST 8'h01
`define MOPS_RELEASE_CYC 4'h2
`endif

// ### rtl/mops_pkg.sv
// Types of the output phase sync block
`default_nettype none
package mops_pkg;
    typedef logic [11:0] mops_addr_t;
    typedef logic [7:0] mops_byte_t;
    typedef enum logic [1:0] {
        MOPS_IDLE = 2'h0,
        MOPS_HOLD = 2'h1,
        MOPS_RELEASE = 2'h3,
        MOPS_ALIGNED = 2'h2
    } mops_state_e;
endpackage
`default_nettype wire

// ### testbench/mops_ref_dist_model.sv
// Behavioural reference and sync distribution partner
`default_nettype none
module mops_ref_dist_model #(
    parameter int PULSE_LEN = 4,
    parameter int STOP_LEN = 3,
    parameter int LOCK_LEN = 5
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic pulse_req_in,
    input wire logic restart_req_in,
    output logic sync_pin_out,
    output logic ref_run_out,
    output logic lock_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int pulse_cnt;
    int stop_cnt;
    int lock_cnt;
    // lock shown after a settle time
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lock_cnt <= 0;
        end else if (lock_cnt < LOCK_LEN) begin
            lock_cnt <= lock_cnt + 1;
        end
    end
    assign lock_out = (lock_cnt == LOCK_LEN);
    // Pulse and reference stop counters
    // fixed width, clean restart
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pulse_cnt <= 0;
            stop_cnt <= 0;
        end else begin
            if (pulse_req_in) pulse_cnt <= PULSE_LEN;
            else if (pulse_cnt > 0) pulse_cnt <= pulse_cnt - 1;
            if (restart_req_in) stop_cnt <= STOP_LEN;
            else if (stop_cnt > 0) stop_cnt <= stop_cnt - 1;
        end
    end
    // Single clean high pin pulse and low reference span, no runt
    assign sync_pin_out = (pulse_cnt > 0);
    assign ref_run_out = (stop_cnt == 0);
endmodule // mops_ref_dist_model
`default_nettype wire

// ### testbench/multichip_output_phase_sync_test.sv
// Self-checking bench of the output phase sync control
`default_nettype none
module multichip_output_phase_sync_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mops_pkg::*;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic wr_en_in = 1'b0;
    mops_addr_t addr_in = 12'h000;
    mops_byte_t wdata_in = 8'h00;
    logic freq_change_in = 1'b0;
    logic pulse_req = 1'b0;
    logic restart_req = 1'b0;
    logic sync_pin;
    logic ref_run;
    mops_byte_t rdata_out;
    logic div_reset_out;
    logic align_done_out;
    logic sync_lvds_sel_out;
    logic ref_type_sel_out;
    logic divided_ref_clock_enable_out;
    logic lock;
    logic [5:0] ref_ratio_out;
    int err_count = 0;
    int samples_checked = 0;
    mops_sync_ctrl i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
        .wr_en_in(wr_en_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .sync_pin_in(sync_pin), .ref_run_in(ref_run),
        .freq_change_in(freq_change_in), .rdata_out(rdata_out),
        .div_reset_out(div_reset_out), .align_done_out(align_done_out),
        .sync_lvds_sel_out(sync_lvds_sel_out),
        .ref_type_sel_out(ref_type_sel_out),
        .divided_ref_clock_enable_out(divided_ref_clock_enable_out),
        .ref_ratio_out(ref_ratio_out));
    mops_ref_dist_model i_dist (.clk_in(clk_in), .nrst_in(nrst_in),
        .pulse_req_in(pulse_req), .restart_req_in(restart_req),
        .sync_pin_out(sync_pin), .ref_run_out(ref_run), .lock_out(lock));
    // Clock of 20 ns period
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input mops_addr_t a, input mops_byte_t d);
        @(posedge clk_in);
        wr_en_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask
    task automatic rd(input mops_addr_t a, output mops_byte_t d);
        @(posedge clk_in);
        addr_in <= a;
        @(posedge clk_in);
        @(negedge clk_in);
        d = rdata_out;
    endtask
    // Bounded wait for reset (0) or done (1)
    task automatic await(input bit on_done, output int n);
        n = 0;
        while ((on_done ? align_done_out : div_reset_out) !== 1'b1 && n < 12)
        begin
            @(negedge clk_in);
            n++;
        end
    endtask
    task automatic fchg(input logic exp);
        freq_change_in <= 1'b1;
        @(posedge clk_in);
        freq_change_in <= 1'b0;
        @(negedge clk_in);
        check(align_done_out, exp);
    endtask
    task automatic t_regs();
        mops_byte_t d;
        rd(12'h020, d);
        check(d, 8'h01);
        check(ref_ratio_out, 8'h01);
        wr(12'h053, 8'h20);
        @(negedge clk_in);
        check(sync_lvds_sel_out, 8'h01);
        rd(12'h053, d);
        check(d, 8'h20);
        wr(12'h030, 8'h20);
        @(negedge clk_in);
        check(ref_type_sel_out, 8'h01);
        wr(12'h02D, 8'h40);
        @(negedge clk_in);
        check(divided_ref_clock_enable_out, 8'h01);
        wr(12'h020, 8'hC4);
        rd(12'h020, d);
        check(d, 8'h04);
        check(ref_ratio_out, 8'h04);
        wr(12'h031, 8'hFF);
        rd(12'h031, d);
        check(d, 8'h00);
        check(ref_type_sel_out, 8'h01);
        wr(12'h053, 8'h00);
        @(negedge clk_in);
        check(sync_lvds_sel_out, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_timed();
        int n;
        wr(12'h01E, 8'hE0);
        check(lock, 8'h01);
        pulse_req <= 1'b1;
        @(posedge clk_in);
        pulse_req <= 1'b0;
        await(0, n);
        check(8'(n >= 1 && n <= 3), 8'h01);
        check(sync_pin, 8'h01);
        while (sync_pin === 1'b1) begin
            check(div_reset_out, 8'h01);
            @(negedge clk_in);
        end
        check(div_reset_out, 8'h01);
        await(1, n);
        check(8'(n >= 2 && n <= 4), 8'h01);
        check(div_reset_out, 8'h00);
        $display("t_timed done");
    endtask
    task automatic t_request();
        int n;
        wr(12'h053, 8'h20);
        wr(12'h01E, 8'hC1);
        check(lock, 8'h01);
        // Pin pulse must be ignored outside timed mode
        pulse_req <= 1'b1;
        @(posedge clk_in);
        pulse_req <= 1'b0;
        repeat (6) begin
            @(negedge clk_in);
            check(div_reset_out, 8'h00);
        end
        @(posedge clk_in);
        restart_req <= 1'b1;
        @(posedge clk_in);
        restart_req <= 1'b0;
        @(negedge clk_in);
        check(div_reset_out, 8'h00);
        await(0, n);
        check(8'(n >= 3 && n <= 6), 8'h01);
        check(align_done_out, 8'h00);
        await(1, n);
        check(8'(n >= 1 && n <= 3), 8'h01);
        check(div_reset_out, 8'h00);
        wr(12'h01E, 8'hC0);
        @(posedge clk_in);
        fchg(1'b1);
        wr(12'h01E, 8'h40);
        fchg(1'b0);
        $display("t_request done");
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog well beyond the run length
    initial begin
        #200000;
        err_count++;
        finish_test();
    end
    // Reset then scenarios
    initial begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        t_regs();
        t_timed();
        t_request();
        finish_test();
    end
endmodule // multichip_output_phase_sync_test
`default_nettype wire
